// *** logic/tms_pkg.sv ***
// constants and types for the touch matrix scan sequencer
// Notes on behaviour
// - each scan pass starts at the lowest enabled key with a nonzero burst (key zero when enabled and its burst is nonzero)
// - step drive lines zero to seven before moving to next receive line
// - key index equals drive line plus eight times receive line
// - matrix is eight drive lines by three receive lines
// - build parameter limits enabled keys to sixteen or twenty-four
// - disabled keys get no burst timeslot
// - key is disabled when its integrator limit is zero
// - never operate with more enabled keys than the variant maximum
// - sixteen-key variant resets with receive line two disabled
// - burst pulse count comes from each key's own setting
// - finish burst and conversion before next key's burst
// - clamp receive line during every drive pulse falling phase
// - after burst clamp, release ramp, count until comparator trips
// - charge capture window after rising edge lasts about 500 ns
package tms_pkg;
  localparam int NUM_X = 8;
  localparam int NUM_Y = 3;
  localparam int NUM_KEYS = NUM_X * NUM_Y;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DWELL_NS = 500;
  localparam int DWELL_CYC = DWELL_NS / CLK_PERIOD_NS;
  localparam int LOW_NS = 500;
  localparam int LOW_CYC = LOW_NS / CLK_PERIOD_NS;
  localparam int CLAMP_NS = 1000;
  localparam int CLAMP_CYC = (CLAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
  localparam logic [7:0] LIMIT_RESET = 8'h02;
  localparam logic [7:0] BURST_RESET = 8'h40;
  typedef enum logic [5:0] {
    TMS_IDLE  = 6'h01,
    TMS_HIGH  = 6'h02,
    TMS_LOW   = 6'h04,
    TMS_CLAMP = 6'h08,
    TMS_RAMP  = 6'h10,
    TMS_DONE  = 6'h20
  } tms_state_t;
endpackage

// *** logic/tms_key_picker.sv ***
// finds next enabled key at or after a start index
`timescale 1ns/1ps
module tms_key_picker (
  input  wire logic [23:0] key_en,
  input  wire logic [4:0]  start,
  output logic             found,
  output logic [4:0]       key
);
  // linear search from the top down, lowest match at or above start wins; wraps to lowest enabled key when nothing above
  always_comb begin
    found = 1'b0;
    key   = 5'h00;
    for (int i = 23; i >= 0; i--) begin
      if (key_en[i] && (5'(i) >= start)) begin
        found = 1'b1;
        key   = 5'(i);
      end
    end
    if (!found) begin
      for (int i = 23; i >= 0; i--) begin
        if (key_en[i]) begin
          found = 1'b1;
          key   = 5'(i);
        end
      end
    end
  end
endmodule // tms_key_picker

// *** logic/tms_scan_seq.sv ***
// touch matrix scan sequencer top
`timescale 1ns/1ps
module tms_scan_seq #(
  parameter int MAX_KEYS = 24
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        cfg_we,
  input  wire logic [4:0]  cfg_key,
  input  wire logic [7:0]  cfg_limit,
  input  wire logic [7:0]  cfg_burst,
  input  wire logic        cfg_commit,
  input  wire logic        ramp_cross,
  output logic [7:0]       x_drive,
  output logic [2:0]       y_clamp,
  output logic [2:0]       ramp_on,
  output logic             res_valid,
  output logic [4:0]       res_key,
  output logic [15:0]      res_count,
  output logic             res_over,
  output logic             cfg_reject,
  output logic             pass_start
);
  localparam logic [4:0] NUM_K = 5'(tms_pkg::NUM_KEYS);

  logic [7:0]  limit_tbl [24];
  logic [7:0]  burst_tbl [24];
  logic [7:0]  stage_lim [24];
  logic [23:0] key_en;
  logic [23:0] stage_en;
  logic        cross_s1;
  logic        cross_s2;
  tms_pkg::tms_state_t state;
  logic [4:0]  cur_key;
  logic [4:0]  next_start;
  logic        pick_found;
  logic [4:0]  pick_key;
  logic [7:0]  pulses;
  logic [15:0] tmr;
  logic [15:0] ramp_cnt;
  logic [5:0]  stage_cnt;
  logic [5:0]  stage_pop;
  logic        seq_fresh;

  // comparator is an async pin: two flops first
  always_ff @(posedge ref_clk) begin
    cross_s1 <= ramp_cross;
    cross_s2 <= cross_s1;
  end

  // staging table for limits; commit applies all staged limits at once, bursts take effect on write
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 24; i++) begin
      if (rst) begin
        stage_lim[i] <= (MAX_KEYS == 16 && i >= 16) ? 8'h00
                        : tms_pkg::LIMIT_RESET;
      end else if (cfg_we && cfg_key == 5'(i)) begin
        stage_lim[i] <= cfg_limit;
      end
    end
  end

  // a key enables when its limit is nonzero
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      stage_en[i] = (stage_lim[i] != 8'h00);
    end
    stage_pop = 6'h00;
    for (int i = 0; i < 24; i++) begin
      stage_pop = stage_pop + 6'(stage_en[i]);
    end
    stage_cnt = stage_pop;
  end

  // commit only when count fits the variant; else keep old set
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 24; i++) begin
        limit_tbl[i] <= (MAX_KEYS == 16 && i >= 16) ? 8'h00
                        : tms_pkg::LIMIT_RESET;
        burst_tbl[i] <= tms_pkg::BURST_RESET;
      end
      cfg_reject <= 1'b0;
    end else begin
      cfg_reject <= 1'b0;
      // indices past the grid are dropped, not written out of range
      if (cfg_we && cfg_key < NUM_K) begin
        burst_tbl[cfg_key] <= cfg_burst;
      end
      if (cfg_commit) begin
        if (stage_cnt <= 6'(MAX_KEYS)) begin
          for (int i = 0; i < 24; i++) begin
            limit_tbl[i] <= stage_lim[i];
          end
        end else begin
          cfg_reject <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 24; i++) begin
      key_en[i] = (limit_tbl[i] != 8'h00);
    end
  end

  // skip disabled keys, wrap to lowest enabled
  tms_key_picker u_pick (
    .key_en (key_en),
    .start  (next_start),
    .found  (pick_found),
    .key    (pick_key)
  );

  // one key at a time: burst, clamp, ramp, then next key
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state      <= tms_pkg::TMS_IDLE;
      cur_key    <= 5'h00;
      next_start <= 5'h00;
      pulses     <= 8'h00;
      tmr        <= 16'h0000;
      ramp_cnt   <= 16'h0000;
      res_valid  <= 1'b0;
      res_key    <= 5'h00;
      res_count  <= 16'h0000;
      res_over   <= 1'b0;
      pass_start <= 1'b0;
      seq_fresh  <= 1'b1;
    end else begin
      res_valid  <= 1'b0;
      pass_start <= 1'b0;
      case (state)
        tms_pkg::TMS_IDLE: begin
          if (pick_found && burst_tbl[pick_key] != 8'h00) begin
            cur_key    <= pick_key;
            pulses     <= burst_tbl[pick_key];
            tmr        <= 16'h0000;
            // a pass begins when the index fails to climb; skipped keys
            // may have moved next_start, so compare with the last burst
            pass_start <= seq_fresh || (pick_key <= cur_key);
            seq_fresh  <= 1'b0;
            state      <= tms_pkg::TMS_HIGH;
          end else if (pick_found) begin
            next_start <= (pick_key == NUM_K - 5'h01) ? 5'h00
                          : pick_key + 5'h01;
          end
        end
        tms_pkg::TMS_HIGH: begin
          if (tmr == 16'(tms_pkg::DWELL_CYC - 1)) begin
            tmr    <= 16'h0000;
            pulses <= pulses - 8'h01;
            state  <= tms_pkg::TMS_LOW;
          end else begin
            tmr <= tmr + 16'h0001;
          end
        end
        tms_pkg::TMS_LOW: begin
          if (tmr == 16'(tms_pkg::LOW_CYC - 1)) begin
            tmr   <= 16'h0000;
            state <= (pulses == 8'h00) ? tms_pkg::TMS_CLAMP
                     : tms_pkg::TMS_HIGH;
          end else begin
            tmr <= tmr + 16'h0001;
          end
        end
        tms_pkg::TMS_CLAMP: begin
          if (tmr == 16'(tms_pkg::CLAMP_CYC - 1)) begin
            tmr      <= 16'h0000;
            ramp_cnt <= 16'h0000;
            state    <= tms_pkg::TMS_RAMP;
          end else begin
            tmr <= tmr + 16'h0001;
          end
        end
        tms_pkg::TMS_RAMP: begin
          if (cross_s2 || ramp_cnt == tms_pkg::CNT_MAX) begin
            res_valid <= 1'b1;
            res_key   <= cur_key;
            res_count <= ramp_cnt;
            res_over  <= !cross_s2;
            state     <= tms_pkg::TMS_DONE;
          end else begin
            ramp_cnt <= ramp_cnt + 16'h0001;
          end
        end
        tms_pkg::TMS_DONE: begin
          // order x then y follows from key index order
          next_start <= (cur_key == NUM_K - 5'h01) ? 5'h00
                        : cur_key + 5'h01;
          state <= tms_pkg::TMS_IDLE;
        end
        default: state <= tms_pkg::TMS_IDLE;
      endcase
    end
  end

  // receive line one-hot from key index: y is key div 8
  function automatic logic [2:0] y_line(input logic [4:0] k);
    return 3'(3'h1 << k[4:3]);
  endfunction

  // pins registered from state; x is key mod 8, y is key div 8
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      x_drive <= 8'h00;
      y_clamp <= 3'h0;
      ramp_on <= 3'h0;
    end else begin
      x_drive <= (state == tms_pkg::TMS_HIGH)
                 ? 8'(8'h01 << cur_key[2:0]) : 8'h00;
      y_clamp <= (state == tms_pkg::TMS_LOW || state == tms_pkg::TMS_CLAMP)
                 ? y_line(cur_key) : 3'h0;
      ramp_on <= (state == tms_pkg::TMS_RAMP)
                 ? y_line(cur_key) : 3'h0;
    end
  end

  property p_no_overlap;
    @(posedge ref_clk) disable iff (rst)
      x_drive != 8'h00 |-> y_clamp == 3'h0;
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("drive and clamp overlap");

  property p_limit;
    @(posedge ref_clk) disable iff (rst)
      $countones(key_en) <= MAX_KEYS;
  endproperty
  a_limit: assert property (p_limit)
    else $error("too many keys enabled");

  property p_enabled_only;
    @(posedge ref_clk) disable iff (rst)
      (state == tms_pkg::TMS_IDLE) && pick_found |-> key_en[pick_key];
  endproperty
  a_enabled_only: assert property (p_enabled_only)
    else $error("result for disabled key");

  property p_over;
    @(posedge ref_clk) disable iff (rst)
      res_valid && res_over |-> res_count == tms_pkg::CNT_MAX;
  endproperty
  a_over: assert property (p_over)
    else $error("out of range without saturation");

  // pulse stays high for the full dwell and drops right after
  localparam int DWELL_M1 = tms_pkg::DWELL_CYC - 1;
  sequence s_dwell;
    ##DWELL_M1 (|x_drive) ##1 !(|x_drive);
  endsequence
  property p_dwell;
    @(posedge ref_clk) disable iff (rst)
      $rose(|x_drive) |-> s_dwell;
  endproperty
  a_dwell: assert property (p_dwell)
    else $error("dwell length wrong");

  // ramp only follows the post-burst clamp on the same line
  property p_ramp_after_clamp;
    @(posedge ref_clk) disable iff (rst)
      $rose(|ramp_on) |-> ramp_on == $past(y_clamp);
  endproperty
  a_ramp_after_clamp: assert property (p_ramp_after_clamp)
    else $error("ramp without clamp before it");

  // default key set seen right as reset lets go
  property p_reset_keys;
    @(posedge ref_clk)
      $fell(rst) |-> key_en == ((MAX_KEYS == 16) ? 24'h00ffff : 24'hffffff);
  endproperty
  a_reset_keys: assert property (p_reset_keys)
    else $error("wrong default key set");
endmodule // tms_scan_seq

// *** tb/tms_matrix_model.sv ***
// electrode matrix model: comparator trips after a set ramp time
`timescale 1ns/1ps
module tms_matrix_model (
  input  wire logic       ref_clk,
  input  wire logic [2:0] ramp_on,
  input  wire logic [7:0] delay,
  output logic            ramp_cross
);
  int n = 0;
  initial ramp_cross = 1'b0;
  // comparator stays low until the ramp has run delay cycles
  always @(posedge ref_clk) begin
    if (|ramp_on === 1'b1) begin
      n <= n + 1;
      ramp_cross <= (n >= delay);
    end else begin
      n <= 0;
      ramp_cross <= 1'b0;
    end
  end
endmodule // tms_matrix_model

// *** tb/tms_scan_seq_test.sv ***
// self-checking bench for the touch matrix scan sequencer
`timescale 1ns/1ps
module tms_scan_seq_test;
  localparam int MAXK = 16;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cfg_we = 1'b0;
  logic [4:0]  cfg_key = 5'h00;
  logic [7:0]  cfg_limit = 8'h00;
  logic [7:0]  cfg_burst = 8'h00;
  logic        cfg_commit = 1'b0;
  logic [7:0]  delay = 8'h05;
  logic        ramp_cross;
  logic [7:0]  x_drive;
  logic [2:0]  y_clamp;
  logic [2:0]  ramp_on;
  logic        res_valid;
  logic [4:0]  res_key;
  logic [15:0] res_count;
  logic        res_over;
  logic        cfg_reject;
  logic        pass_start;
  logic [31:0] seed = 32'd40;
  logic [7:0]  burst [24];
  bit          en [24];
  logic [4:0]  got [$];
  logic [7:0]  cur_x = 8'h00;
  logic [7:0]  prev_x = 8'h00;
  logic [2:0]  cur_y = 3'h0;
  int          pulses = 0;
  bit          armed = 0;
  int          num_errors = 0;
  int          num_checks = 0;

  always #5 ref_clk = ~ref_clk;

  tms_scan_seq #(.MAX_KEYS(MAXK)) DUT (.ref_clk(ref_clk), .rst(rst),
    .cfg_we(cfg_we), .cfg_key(cfg_key), .cfg_limit(cfg_limit),
    .cfg_burst(cfg_burst), .cfg_commit(cfg_commit),
    .ramp_cross(ramp_cross), .x_drive(x_drive), .y_clamp(y_clamp),
    .ramp_on(ramp_on), .res_valid(res_valid), .res_key(res_key),
    .res_count(res_count), .res_over(res_over),
    .cfg_reject(cfg_reject), .pass_start(pass_start));

  tms_matrix_model u_model (.ref_clk(ref_clk), .ramp_on(ramp_on),
    .delay(delay), .ramp_cross(ramp_cross));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected {receive, drive} one-hot pair for a key index
  function automatic logic [10:0] exp_lines(input logic [4:0] k);
    return {3'(3'h1 << k[4:3]), 8'(8'h01 << k[2:0])};
  endfunction

  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // watch the matrix lines; each result in an armed pass is checked against its burst
  always @(posedge ref_clk) begin
    if (|x_drive === 1'b1 && |y_clamp === 1'b1) check_val(1, 0);
    if (|x_drive === 1'b1 && prev_x === 8'h00) pulses++;
    if (|x_drive === 1'b1) cur_x = x_drive;
    if (|ramp_on === 1'b1) cur_y = ramp_on;
    prev_x = x_drive;
    if (res_valid === 1'b1) begin
      got.push_back(res_key);
      if (armed) begin
        check_val(pulses, burst[res_key]);
        check_val({cur_y, cur_x}, exp_lines(res_key));
        check_val(res_count >= delay && res_count <= delay + 5, 1);
        check_val(res_over, 0);
      end
      pulses = 0;
    end
  end

  // one full pass between two pass starts, compared slot by slot
  task automatic run_pass();
    logic [4:0] exp [$];
    @(posedge ref_clk iff pass_start === 1'b1);
    @(negedge ref_clk);
    armed = 1;
    got.delete();
    @(posedge ref_clk iff pass_start === 1'b1);
    @(negedge ref_clk);
    armed = 0;
    // zero-burst keys are skipped like disabled ones
    for (int k = 0; k < 24; k++)
      if (en[k] && burst[k] != 8'h00) exp.push_back(5'(k));
    check_val(got.size(), exp.size());
    foreach (exp[i]) if (i < got.size()) check_val(got[i], exp[i]);
    $display("pass test done, %0d slots", exp.size());
  endtask

  // stage limits and write bursts for all keys, then commit the limits together
  task automatic load(input int mode);
    int  cnt;
    bit  st [24];
    logic rej;
    cnt = 0;
    armed = 0;
    delay = 8'(3 + xs() % 60);
    for (int k = 0; k < 24; k++) begin
      st[k] = mode == 2 || (mode == 1 ? k >= 22 : xs() % 2 == 0 && cnt < MAXK);
      cnt += st[k];
      cfg_we = 1'b1;
      cfg_key = 5'(k);
      cfg_limit = st[k] ? 8'(1 + xs() % 200) : 8'h00;
      // corner: key 22 enabled but with a zero burst must be skipped
      cfg_burst = (mode == 1 && k == 22) ? 8'h00 : 8'(1 + xs() % 3);
      burst[k] = cfg_burst;
      @(negedge ref_clk);
    end
    cfg_we = 1'b0;
    cfg_commit = 1'b1;
    @(negedge ref_clk);
    cfg_commit = 1'b0;
    rej = cfg_reject;
    @(negedge ref_clk);
    rej = rej | cfg_reject;
    check_val(rej, cnt > MAXK);
    if (cnt <= MAXK) en = st;
    run_pass();
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence: reset, defaults, random loads, refusal, single key
  initial begin
    repeat (8) @(negedge ref_clk);
    check_val({x_drive, y_clamp, ramp_on, res_valid}, 0);
    rst = 1'b0;
    @(posedge ref_clk iff |x_drive === 1'b1);
    check_val(x_drive, 8'h01);
    $display("reset test done");
    @(negedge ref_clk);
    load(0);
    load(0);
    load(2);
    load(1);
    report_and_stop();
  end

  // cuts a hang short after far more than the passes need
  initial begin
    #900us;
    num_errors++;
    report_and_stop();
  end
endmodule // tms_scan_seq_test
